// ==== fpm_host_model.sv ====
// Host serial controller model: drives select, serial clock and data pins
`timescale 1ns/100ps

module fpm_host_model (
  input wire logic clk_in,      // System clock
  output logic chip_sel_n_out,  // Chip select, active low
  output logic sclk_out,        // Serial clock, idles low
  output logic sdi_out          // Serial data, MSB first
);
  // Clock-high time in clk cycles, a third of the serial period; must exceed the pin filter depth
  localparam int HALF = 5;

  // Pins idle: deselected, clock still
  initial begin
    chip_sel_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  // All pin changes land on falling edges, away from the sampling edge
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Select low opens a frame
  task automatic sel_low();
    idle(1);
    chip_sel_n_out = 1'b0;
  endtask

  // Shift n bits of op; the clock only moves inside a frame
  task automatic shift(input logic [7:0] op, input int n);
    for (int i = 0; i < n; i++) begin
      idle(HALF);
      sdi_out = op[7 - (i % 8)];
      idle(HALF);
      sclk_out = 1'b1;
      idle(HALF);
      sclk_out = 1'b0;
    end
  endtask

  // Close frame; data line flips so a released line never holds its value
  task automatic sel_high();
    idle(HALF);
    chip_sel_n_out = 1'b1;
    sdi_out = ~sdi_out;
    // Gap before any later select edge, so no edge comes without a real frame
    idle(HALF);
  endtask
endmodule

// ==== fpm_params.svh ====
// Constants for the flash power-mode control block: opcodes and timing counts
`ifndef FPM_PARAMS_SVH
`define FPM_PARAMS_SVH

// Command opcodes seen as the first byte of a frame
`define FPM_OP_ENTER_SLEEP 8'hB9
`define FPM_OP_RELEASE 8'hAB

// Number of serial clock edges that make a whole opcode byte
`define FPM_BITS_PER_CMD 4'h8

// System clock period, 10 MHz
`define FPM_CLK_PERIOD_NS 100

// Least sleep-entry and release delays in ns (plain defaults)
`define FPM_SLEEP_ENTRY_NS 3000
`define FPM_RELEASE_NS 30000

// Least times round up to whole cycles, never below one cycle
`define FPM_NS_TO_CYC(ns) \
  ((((ns) + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS))
`define FPM_SLEEP_ENTRY_CYC `FPM_NS_TO_CYC(`FPM_SLEEP_ENTRY_NS)
`define FPM_RELEASE_CYC `FPM_NS_TO_CYC(`FPM_RELEASE_NS)

// Reset levels of the synchronised pins: select idle high, clock and data low
`define FPM_PIN_RESET 3'h4

`endif

// ==== fpm_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module fpm_pin_sync #(
  parameter int W = 3,                    // Number of pins
  parameter logic [W-1:0] RST_VAL = '0    // Level held during reset
) (
  input wire logic clk_in,                // System clock
  input wire logic rst_n_in,              // Async reset, active low
  input wire logic [W-1:0] pin_in,        // Raw pin levels
  output logic [W-1:0] level_out          // Filtered levels
);

  logic [W-1:0] stage1; // Metastability catcher, read by stage2 only
  logic [W-1:0] stage2; // Second stage
  logic [W-1:0] stage3; // Third stage

  // Shift chain; stage1 feeds nothing but stage2
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once stages two and three agree, per bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// ==== fpm_pkg.sv ====
// Types shared by the flash power-mode control block
package fpm_pkg;

  // Power states of the device
  typedef enum logic [2:0] {
    FPM_ACTIVE       = 3'b000,
    FPM_STANDBY      = 3'b001,
    FPM_ENTER_WAIT   = 3'b010,
    FPM_DEEP_SLEEP   = 3'b011,
    FPM_RELEASE_WAIT = 3'b100
  } fpm_state_t;

endpackage

// ==== fpm_power_ctrl.sv ====
// Power-mode state logic of a serial flash: active, standby, deep sleep
`timescale 1ns/100ps
`include "fpm_params.svh"

module fpm_power_ctrl
  import fpm_pkg::*;
#(
  parameter int SLEEP_ENTRY_CYC = `FPM_SLEEP_ENTRY_CYC, // Sleep-entry delay in cycles
  parameter int RELEASE_CYC = `FPM_RELEASE_CYC          // Release delay in cycles
) (
  input wire logic clk_in,                  // 10 MHz system clock
  input wire logic rst_n_in,                // Async reset, active low
  input wire logic chip_sel_n_in,           // Chip select pin, active low
  input wire logic sclk_in,                 // Serial clock pin
  input wire logic sdi_in,                  // Serial data in pin
  input wire logic write_in_progress_flag_in, // Bit 0 of volatile_status_one
  output logic [2:0] power_state_out,       // Current power state code
  output logic active_out,                  // Active power state
  output logic standby_out,                 // Standby power state
  output logic deep_sleep_state_out,        // Deep sleep reached
  output logic cmd_enable_out               // Command decoder may act
);

  logic [2:0] pins;        // Filtered {select_n, sclk, sdi}
  logic cs_n;              // Filtered select, active low
  logic sck;               // Filtered serial clock
  logic sdi;               // Filtered serial data
  logic cs_n_prev;         // Select one cycle ago
  logic sck_prev;          // Clock one cycle ago
  logic cs_rise;           // End of frame
  logic cs_fall;           // Start of frame
  logic sck_rise;          // Bit sample point
  logic frame_ok;          // Frame started outside a delay
  logic [3:0] bit_cnt;     // Bits in frame, saturating
  logic [7:0] opcode;      // First byte of frame
  logic [15:0] wait_cnt;   // Delay counter
  logic is_enter_cmd;      // Whole B9h byte received
  logic is_release_cmd;    // Whole ABh byte received
  fpm_state_t state;       // Power state
  fpm_state_t next_state;  // Next power state

  // Pins come from the host's domain, so all three pass the filter
  fpm_pin_sync #(
    .W(3),
    .RST_VAL(`FPM_PIN_RESET)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in({chip_sel_n_in, sclk_in, sdi_in}),
    .level_out(pins)
  );

  assign cs_n = pins[2];
  assign sck = pins[1];
  assign sdi = pins[0];
  assign cs_rise = cs_n && !cs_n_prev;
  assign cs_fall = !cs_n && cs_n_prev;
  assign sck_rise = sck && !sck_prev;

  // Edge history of the filtered pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_n_prev <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      cs_n_prev <= cs_n;
      sck_prev <= sck;
    end
  end

  // A frame opened during a delay is marked dead for its whole length
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_ok <= 1'b0;
    end else if (cs_fall) begin
      frame_ok <= (state != FPM_ENTER_WAIT) && (state != FPM_RELEASE_WAIT);
    end
  end

  // Shift in the opcode; bits past the first byte only bump the count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt <= 4'h0;
      opcode <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt <= 4'h0;
    end else if (!cs_n && sck_rise) begin
      if (bit_cnt != 4'hF) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (bit_cnt < `FPM_BITS_PER_CMD) begin
        opcode <= {opcode[6:0], sdi};
      end
    end
  end

  // Only a frame of exactly one byte counts; a frame without clocks never does
  assign is_enter_cmd = frame_ok && (bit_cnt == `FPM_BITS_PER_CMD)
    && (opcode == `FPM_OP_ENTER_SLEEP);
  assign is_release_cmd = frame_ok && (bit_cnt == `FPM_BITS_PER_CMD)
    && (opcode == `FPM_OP_RELEASE);

  // State transitions
  always_comb begin
    next_state = state;
    unique case (state)
      FPM_ACTIVE: begin
        // Deselected: either start sleep entry or drop to standby when idle
        if (cs_n && !write_in_progress_flag_in) begin
          if (cs_rise && is_enter_cmd) begin
            next_state = FPM_ENTER_WAIT;
          end else begin
            next_state = FPM_STANDBY;
          end
        end
      end
      FPM_STANDBY: begin
        if (!cs_n) begin
          next_state = FPM_ACTIVE;
        end
      end
      FPM_ENTER_WAIT: begin
        if (wait_cnt == 16'(SLEEP_ENTRY_CYC - 1)) begin
          next_state = FPM_DEEP_SLEEP;
        end
      end
      FPM_DEEP_SLEEP: begin
        // Everything but a whole release byte is ignored here
        if (cs_rise && is_release_cmd) begin
          next_state = FPM_RELEASE_WAIT;
        end
      end
      FPM_RELEASE_WAIT: begin
        if (wait_cnt == 16'(RELEASE_CYC - 1)) begin
          next_state = FPM_STANDBY;
        end
      end
      default: begin
        next_state = FPM_STANDBY;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= FPM_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // Delay counter restarts on every state change, counts inside the waits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 16'h0000;
    end else if (next_state != state) begin
      wait_cnt <= 16'h0000;
    end else if (state == FPM_ENTER_WAIT || state == FPM_RELEASE_WAIT) begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  // Outputs decoded from the next state so they line up with the state flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_state_out <= FPM_STANDBY;
      active_out <= 1'b0;
      standby_out <= 1'b1;
      deep_sleep_state_out <= 1'b0;
      cmd_enable_out <= 1'b1;
    end else begin
      power_state_out <= next_state;
      active_out <= (next_state == FPM_ACTIVE);
      standby_out <= (next_state == FPM_STANDBY);
      deep_sleep_state_out <= (next_state == FPM_DEEP_SLEEP);
      // Decoder is shut out during sleep and both delays
      cmd_enable_out <= (next_state == FPM_ACTIVE) || (next_state == FPM_STANDBY);
    end
  end

  // Checks on the power-state sequence
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_select_goes_active: assert property (
    state == FPM_STANDBY && !cs_n |=> state == FPM_ACTIVE && active_out)
    else $error("Selected standby device did not become active");

  a_active_while_busy: assert property (
    state == FPM_ACTIVE && write_in_progress_flag_in |=> state == FPM_ACTIVE)
    else $error("Device left active state while write in progress");

  a_idle_to_standby: assert property (
    state == FPM_ACTIVE && cs_n && !write_in_progress_flag_in && !cs_rise
    |=> state == FPM_STANDBY)
    else $error("Idle deselected device did not reach standby");

  a_enter_on_opcode: assert property (
    state == FPM_ACTIVE && cs_rise && is_enter_cmd && !write_in_progress_flag_in
    |=> state == FPM_ENTER_WAIT)
    else $error("Enter-sleep opcode did not start sleep entry");

  a_enter_needs_idle: assert property (
    state != FPM_ENTER_WAIT ##1 state == FPM_ENTER_WAIT
    |-> $past(!write_in_progress_flag_in) && $past(cs_rise))
    else $error("Sleep entry started while busy or selected");

  a_sleep_holds: assert property (
    state == FPM_DEEP_SLEEP && !(cs_rise && is_release_cmd)
    |=> state == FPM_DEEP_SLEEP && deep_sleep_state_out)
    else $error("Deep sleep left without a release opcode");

  a_release_delay: assert property (
    state == FPM_RELEASE_WAIT ##1 state != FPM_RELEASE_WAIT
    |-> state == FPM_STANDBY && $past(wait_cnt) == 16'(RELEASE_CYC - 1))
    else $error("Release left its delay at the wrong count");

  a_entry_delay: assert property (
    state == FPM_ENTER_WAIT ##1 state != FPM_ENTER_WAIT
    |-> state == FPM_DEEP_SLEEP && $past(wait_cnt) == 16'(SLEEP_ENTRY_CYC - 1))
    else $error("Sleep entry left its delay at the wrong count");

  a_idle_frame_sleeps: assert property (
    state == FPM_DEEP_SLEEP && cs_rise && bit_cnt == 4'h0 |=> state == FPM_DEEP_SLEEP)
    else $error("Frame without clocks woke the device");

  a_wait_drops_cmds: assert property (
    (state == FPM_ENTER_WAIT || state == FPM_RELEASE_WAIT) && cs_fall
    |=> !frame_ok ##1 !cmd_enable_out || state == FPM_STANDBY)
    else $error("Frame opened during a delay was not ignored");

  c_enter_sleep: cover property (
    state == FPM_ENTER_WAIT ##1 state == FPM_DEEP_SLEEP);
  c_release: cover property (
    state == FPM_RELEASE_WAIT ##1 state == FPM_STANDBY);
  c_wrong_cmd_asleep: cover property (
    state == FPM_DEEP_SLEEP && cs_rise && bit_cnt == `FPM_BITS_PER_CMD && !is_release_cmd);
  c_busy_then_standby: cover property (
    state == FPM_ACTIVE && cs_n && write_in_progress_flag_in
    ##1 state == FPM_ACTIVE && !write_in_progress_flag_in ##1 state == FPM_STANDBY);

endmodule

// ==== testbench.sv ====
// Self-checking testbench for the flash power-mode control block
`timescale 1ns/100ps

module testbench
  import fpm_pkg::*;
;
  localparam int S_CYC = 10;   // Short sleep-entry delay keeps the run brief
  localparam int R_CYC = 200;  // Release delay long enough to hold a whole frame
  typedef struct {
    logic [7:0] op;
    int n;
    logic [2:0] exp;
  } fpm_row_t;

  logic clk_in = 1'b0;    // System clock
  logic rst_n_in = 1'b0;  // Reset, active low
  logic write_in_progress_flag = 1'b0;       // Write flag into the block
  logic cs_n;             // Select pin from host
  logic sclk;             // Serial clock from host
  logic sdi;              // Serial data from host
  logic [2:0] state;      // State code
  logic act;              // Active level
  logic stb;              // Standby level
  logic slp;              // Deep sleep level
  logic cen;              // Decoder enable
  logic [6:0] seen_word;  // All outputs side by side
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Ordinary frames: opcode, bit count, state expected once settled
  fpm_row_t rows [6] = '{
    '{8'h9F, 8, FPM_STANDBY}, '{8'hB9, 7, FPM_STANDBY}, '{8'hB9, 8, FPM_DEEP_SLEEP},
    '{8'hB9, 8, FPM_DEEP_SLEEP}, '{8'hAB, 7, FPM_DEEP_SLEEP}, '{8'hAB, 8, FPM_STANDBY}};

  // 100 ns period
  always #50 clk_in = ~clk_in;

  assign seen_word = {state, act, stb, slp, cen};

  // Watchdog: the full run needs about 3100 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      tally_and_finish();
    end
  end

  fpm_host_model i_host (
    .clk_in(clk_in),
    .chip_sel_n_out(cs_n),
    .sclk_out(sclk),
    .sdi_out(sdi)
  );

  fpm_power_ctrl #(.SLEEP_ENTRY_CYC(S_CYC), .RELEASE_CYC(R_CYC)) i_dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .chip_sel_n_in(cs_n),
    .sclk_in(sclk),
    .sdi_in(sdi),
    .write_in_progress_flag_in(write_in_progress_flag),
    .power_state_out(state),
    .active_out(act),
    .standby_out(stb),
    .deep_sleep_state_out(slp),
    .cmd_enable_out(cen)
  );

  // Compare and count; four-state equality so unknowns fail
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Expected word for a power state: {state, active, standby, sleep, enable}
  function automatic logic [6:0] exp_word(input logic [2:0] s);
    return {s, s == FPM_ACTIVE, s == FPM_STANDBY, s == FPM_DEEP_SLEEP,
      (s == FPM_ACTIVE) || (s == FPM_STANDBY)};
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Frame helper: whole opcode then deselect
  task automatic frame(input logic [7:0] op, input int n);
    i_host.sel_low();
    i_host.shift(op, n);
    i_host.sel_high();
  endtask

  initial begin
    logic [2:0] prev;
    prev = FPM_STANDBY;
    @(negedge clk_in);
    check(seen_word, exp_word(FPM_STANDBY));
    @(negedge clk_in);
    check(seen_word, exp_word(FPM_STANDBY));
    rst_n_in = 1'b1;
    i_host.idle(6);
    // Table pass; asleep, select low must not wake the part
    foreach (rows[i]) begin
      i_host.sel_low();
      i_host.shift(rows[i].op, rows[i].n);
      check(seen_word, exp_word((prev == FPM_STANDBY) ? FPM_ACTIVE : prev));
      i_host.sel_high();
      i_host.idle(R_CYC + 12);
      check(seen_word, exp_word(rows[i].exp));
      prev = rows[i].exp;
    end
    // Entry delay: sleep entry starts 5 edges after the select rise, then S_CYC cycles of waiting
    frame(8'hB9, 8);
    i_host.idle(S_CYC - 1);
    check(seen_word, exp_word(FPM_ENTER_WAIT));
    i_host.idle(1);
    check(seen_word, exp_word(FPM_DEEP_SLEEP));
    i_host.idle(10);
    check(seen_word, exp_word(FPM_DEEP_SLEEP));
    // Select pulse with a still clock keeps sleep
    i_host.sel_low();
    i_host.idle(20);
    i_host.sel_high();
    i_host.idle(20);
    check(seen_word, exp_word(FPM_DEEP_SLEEP));
    // Release, then an enter-sleep frame opened in the delay and closed after it
    frame(8'hAB, 8);
    i_host.idle(3);
    check(seen_word, exp_word(FPM_RELEASE_WAIT));
    i_host.idle(R_CYC - 100);
    i_host.sel_low();
    i_host.shift(8'hB9, 8);
    check(seen_word, exp_word(FPM_ACTIVE));
    i_host.sel_high();
    check(seen_word, exp_word(FPM_STANDBY));
    i_host.idle(S_CYC + 12);
    check(seen_word, exp_word(FPM_STANDBY));
    // Write busy: enter-sleep refused, active until the flag clears
    write_in_progress_flag = 1'b1;
    frame(8'hB9, 8);
    i_host.idle(20);
    check(seen_word, exp_word(FPM_ACTIVE));
    write_in_progress_flag = 1'b0;
    i_host.idle(1);
    check(seen_word, exp_word(FPM_STANDBY));
    i_host.idle(S_CYC + 12);
    check(seen_word, exp_word(FPM_STANDBY));
    // Reset while asleep: back to standby, and a plain frame works again
    frame(8'hB9, 8);
    i_host.idle(S_CYC + 12);
    check(seen_word, exp_word(FPM_DEEP_SLEEP));
    rst_n_in = 1'b0;
    i_host.idle(2);
    check(seen_word, exp_word(FPM_STANDBY));
    rst_n_in = 1'b1;
    i_host.idle(6);
    i_host.sel_low();
    i_host.shift(8'h9F, 8);
    check(seen_word, exp_word(FPM_ACTIVE));
    i_host.sel_high();
    check(seen_word, exp_word(FPM_STANDBY));
    tally_and_finish();
  end
endmodule
